// file: src/adc_sequence_and_clock_control.sv
// Purpose: channel sequencing, conversion clock choice, standby and parallel strobes
// Assumes: all pins synchronous to hclk; conversion core consumes busy, channel, done
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Added by the designer: the AHB-Lite register port and the register offsets.
module adc_sequence_and_clock_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic load_strobe_n,
  input wire logic [3:0] data_in,
  output logic [adc_ctrl_pkg::RESULT_W-1:0] data_out,
  output logic data_oe,
  input wire logic ext_clock_or_include_ch1,
  input wire logic clock_source_or_include_ch2,
  input wire logic include_ch3,
  input wire logic include_ch4,
  input wire logic pin_vs_register_sel,
  input wire logic standby_n,
  input wire logic sample_start,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] conv_result,
  output logic busy,
  output logic conversion_done_pulse_n,
  output logic [1:0] conv_channel,
  output logic standby_active
);
  import adc_ctrl_pkg::*;

  seq_state_type state_reg, state_next;
  logic [3:0] pending_reg, pending_next;
  logic [3:0] tick_cnt_reg, tick_cnt_next;
  logic clock_ext_reg, clock_ext_next;
  logic busy_reg, busy_next;
  logic done_n_reg, done_n_next;
  logic [RESULT_W-1:0] result_reg, result_next;
  logic [COUNT_W-1:0] count_reg, count_next;
  logic [3:0] chan_sel_reg, chan_sel_next;
  logic [DIV_W-1:0] int_div_reg, int_div_next;
  ahb_phase_type phase_reg, phase_next;
  logic [31:0] rdata_reg, rdata_next;

  logic start_rise;
  logic load_rise;
  logic ext_rise;
  logic int_tick;
  logic conv_tick;
  logic register_mode;
  logic ext_selected;
  logic [3:0] pin_mask;
  logic [3:0] lowest;
  logic [1:0] lowest_index;
  status_type status;

  edge_rise #(.INIT(1'b0)) start_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(sample_start),
    .rise(start_rise)
  );

  // Strobe idles high, so assume high before reset release
  edge_rise #(.INIT(1'b1)) load_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(load_strobe_n),
    .rise(load_rise)
  );

  edge_rise #(.INIT(1'b0)) ext_clock_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(ext_clock_or_include_ch1),
    .rise(ext_rise)
  );

  // oscillator stops
  // Internal oscillator halted in standby to save power
  int_clock_gen internal_clock (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(standby_n),
    .divide(int_div_reg),
    .tick(int_tick)
  );

  assign register_mode = pin_vs_register_sel;
  assign ext_selected = register_mode & clock_source_or_include_ch2;
  assign pin_mask = {include_ch4, include_ch3, clock_source_or_include_ch2,
                     ext_clock_or_include_ch1};

  assign conv_tick = clock_ext_reg ? ext_rise : int_tick;

  // Lowest pending channel converts first
  assign lowest = pending_reg & (~pending_reg + MASK_ONE);

  always_comb begin
    lowest_index = 2'd0;
    case (lowest)
      4'h2: lowest_index = 2'd1;
      4'h4: lowest_index = 2'd2;
      4'h8: lowest_index = 2'd3;
      default: lowest_index = 2'd0;
    endcase
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    pending_next = pending_reg;
    tick_cnt_next = tick_cnt_reg;
    clock_ext_next = clock_ext_reg;
    busy_next = busy_reg;
    done_n_next = 1'b1;
    result_next = result_reg;
    count_next = count_reg;
    case (state_reg)
      SEQ_IDLE: begin
        // busy at start
        // A start while in standby is ignored
        if (start_rise && standby_n) begin
          pending_next = register_mode ? chan_sel_reg : pin_mask;
          clock_ext_next = ext_selected;
          tick_cnt_next = '0;
          busy_next = 1'b1;
          state_next = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        if (!standby_n) begin
          pending_next = MASK_NONE;
          busy_next = 1'b0;
          state_next = SEQ_IDLE;
        end else if (pending_reg == MASK_NONE) begin
          busy_next = 1'b0;
          state_next = SEQ_IDLE;
        end else if (conv_tick) begin
          if (tick_cnt_reg == CONV_LAST_TICK) begin
            tick_cnt_next = '0;
            pending_next = pending_reg & ~lowest;
            done_n_next = 1'b0;
            result_next = conv_result;
            count_next = count_reg + COUNT_ONE;
          end else begin
            tick_cnt_next = tick_cnt_reg + 4'h1;
          end
        end
      end
      default: begin
        pending_next = MASK_NONE;
        busy_next = 1'b0;
        state_next = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SEQ_IDLE;
      pending_reg <= MASK_NONE;
      tick_cnt_reg <= '0;
      clock_ext_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_n_reg <= 1'b1;
      result_reg <= RESULT_RESET;
      count_reg <= COUNT_RESET;
    end else begin
      state_reg <= state_next;
      pending_reg <= pending_next;
      tick_cnt_reg <= tick_cnt_next;
      clock_ext_reg <= clock_ext_next;
      busy_reg <= busy_next;
      done_n_reg <= done_n_next;
      result_reg <= result_next;
      count_reg <= count_next;
    end
  end

  assign status = '{unused: '0, chan_sel: chan_sel_reg, pending: pending_reg,
                    channel: lowest_index, clock_external: clock_ext_reg,
                    register_mode: register_mode, standby: ~standby_n,
                    spare: 2'b00, busy: busy_reg};

  // Channel select load and AHB-Lite slave
  always_comb begin
    chan_sel_next = chan_sel_reg;
    int_div_next = int_div_reg;
    phase_next = phase_reg;
    rdata_next = rdata_reg;
    if (load_rise && !chip_select_n && read_strobe_n) begin
      chan_sel_next = data_in;
    end
    if (phase_reg.valid && phase_reg.write && phase_reg.addr == CTRL_OFFSET) begin
      int_div_next = hwdata[DIV_W-1:0];
    end
    if (hready) begin
      phase_next.valid = hsel & (htrans == HTRANS_NONSEQ);
      phase_next.write = hwrite;
      phase_next.addr = haddr[ADDR_DEC_W-1:0];
      rdata_next = WORD_ZERO;
      if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
        case (haddr[ADDR_DEC_W-1:0])
          CTRL_OFFSET: rdata_next = {{(32 - DIV_W){1'b0}}, int_div_reg};
          STATUS_OFFSET: rdata_next = status;
          COUNT_OFFSET: rdata_next = {{(32 - COUNT_W){1'b0}}, count_reg};
          default: rdata_next = WORD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_sel_reg <= CHAN_SEL_RESET;
      int_div_reg <= INT_DIV_RESET;
      phase_reg <= '0;
      rdata_reg <= WORD_ZERO;
    end else begin
      chan_sel_reg <= chan_sel_next;
      int_div_reg <= int_div_next;
      phase_reg <= phase_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_reg;

  // drive only on read
  // Load strobe is not checked here; the host keeps it high during reads
  assign data_oe = ~read_strobe_n & ~chip_select_n;
  assign data_out = result_reg;

  assign busy = busy_reg;
  assign conversion_done_pulse_n = done_n_reg;
  assign conv_channel = lowest_index;
  assign standby_active = ~standby_n;
endmodule // adc_sequence_and_clock_control

// file: src/adc_ctrl_pkg.sv
// Purpose: shared constants and types of the converter sequence and clock control
// Assumes: one 40 MHz clock, AHB-Lite register access with 32-bit data
// Notes: offsets are byte addresses of aligned words
package adc_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CHANNELS = 4;
  localparam int RESULT_W = 14;
  localparam int CONV_CLOCKS = 16;
  localparam logic [3:0] CONV_LAST_TICK = 4'(CONV_CLOCKS - 1);
  localparam int DIV_W = 8;
  localparam int COUNT_W = 16;
  localparam logic [DIV_W-1:0] INT_DIV_RESET = 8'h01;
  localparam logic [3:0] CHAN_SEL_RESET = 4'h0;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_ONE = 4'h1;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 14'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;
  localparam int ADDR_DEC_W = 8;

  // Bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_state_type;

  // Status word, high bits first in the register
  typedef struct packed {
    logic [COUNT_W-1:0] unused;
    logic [3:0] chan_sel;
    logic [3:0] pending;
    logic [1:0] channel;
    logic clock_external;
    logic register_mode;
    logic standby;
    logic [1:0] spare;
    logic busy;
  } status_type;

  typedef struct packed {
    logic write;
    logic valid;
    logic [ADDR_DEC_W-1:0] addr;
  } ahb_phase_type;
endpackage

// file: src/adc_ctrl_helpers.sv
// Purpose: rising edge finder and internal conversion clock divider
// Assumes: inputs synchronous to hclk
// Notes: INIT sets the assumed level before reset release to avoid a false edge
module edge_rise #(
  parameter logic INIT = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level,
  output logic rise
);
  logic prev_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= INIT;
    end else begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
endmodule // edge_rise

module int_clock_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [adc_ctrl_pkg::DIV_W-1:0] divide,
  output logic tick
);
  import adc_ctrl_pkg::*;
  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] count_next;

  // A tick every divide+1 cycles; held at zero while disabled
  always_comb begin
    count_next = count_reg;
    tick = 1'b0;
    if (!enable) begin
      count_next = '0;
    end else if (count_reg >= divide) begin
      count_next = '0;
      tick = 1'b1;
    end else begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule // int_clock_gen

// file: bench/adc_ctrl_properties.sv
// Purpose: timing checks on strobe, standby and sequence outputs
// Assumes: one clock domain
// Notes: lengths are lower bounds, tick phase varies
module adc_ctrl_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic standby_n,
  input wire logic sample_start,
  input wire logic data_oe,
  input wire logic standby_active,
  input wire logic busy,
  input wire logic conversion_done_pulse_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A conversion needs at least sixteen ticks
  sequence quiet_run;
    conversion_done_pulse_n [*8] ##1 conversion_done_pulse_n [*7];
  endsequence
  AST_OE:
    assert property (data_oe == (!read_strobe_n && !chip_select_n)) else $error("oe");
  AST_STANDBY_N_LEVEL:
    assert property (standby_active == !standby_n) else $error("standby level");
  AST_STANDBY_N_IDLE:
    assert property (!standby_n |=> !busy) else $error("busy in standby");
  AST_BUSY_RISE:
    assert property ($rose(sample_start) && !busy && standby_n |=> busy) else $error("no busy");
  AST_DONE_WIDTH:
    assert property ($fell(conversion_done_pulse_n) |=> conversion_done_pulse_n)
      else $error("done width");
  AST_DONE_IN_SEQ:
    assert property (!conversion_done_pulse_n |-> busy) else $error("done when idle");
  AST_CONV_FIRST:
    assert property ($rose(busy) |-> quiet_run) else $error("first too short");
  AST_CONV_GAP:
    assert property ($rose(conversion_done_pulse_n) && busy |-> quiet_run) else $error("gap");
  AST_BUSY_FALL:
    assert property ($fell(busy) |-> !$past(conversion_done_pulse_n) || !$past(standby_n)
      || !$past(busy, 2)) else $error("busy fell early");
endmodule // adc_ctrl_properties
bind adc_sequence_and_clock_control adc_ctrl_properties i_adc_ctrl_properties (.hclk,
  .hresetn, .chip_select_n, .read_strobe_n, .standby_n, .sample_start, .data_oe,
  .standby_active, .busy, .conversion_done_pulse_n);

// file: bench/host_bus_model.sv
// Purpose: host side of the strobe bus and external clock source
// Assumes: one load at a time, reads only while idle
// Notes: released data lines show the inverse value
module host_bus_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load_req,
  input wire logic read_req,
  input wire logic clk_on,
  input wire logic [3:0] value,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic load_strobe_n,
  output logic [3:0] data_in,
  output logic ext_clock
);
  logic [1:0] step_reg;
  logic [1:0] step_next;
  logic clk_next;
  always_comb begin
    step_next = step_reg - 2'(step_reg != 2'h0);
    if (load_req && step_reg == 2'h0) begin
      step_next = 2'h3;
    end
    clk_next = clk_on & !ext_clock;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_reg <= 2'h0;
      ext_clock <= 1'b0;
    end else begin
      step_reg <= step_next;
      ext_clock <= clk_next;
    end
  end
  assign chip_select_n = !(read_req || step_reg != 2'h0);
  assign read_strobe_n = !(read_req && step_reg == 2'h0);
  assign load_strobe_n = !step_reg[1];
  assign data_in = (step_reg != 2'h0) ? value : ~value;
endmodule // host_bus_model

// file: bench/adc_sequence_and_clock_control_test.sv
// Purpose: self-checking bench of the sequence and clock control
// Assumes: zero wait slave, host model on the strobe pins
// Notes: conversion lengths checked as windows
module adc_sequence_and_clock_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, load_req = 0, read_req = 0;
  logic clk_on = 0, mode = 0, standby_n = 1, sample_start = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [3:0] value = 4'h8, incs = 4'h7, data_in;
  logic [RESULT_W-1:0] result = 14'h1a5c, data_out;
  logic hreadyout, hresp, data_oe, ext_clock, cs_n, rd_n, ld_n, busy, done_n;
  logic [1:0] chan;
  int n_mismatch = 0;
  int checks_done = 0;
  always #12.5 hclk = ~hclk;
  adc_sequence_and_clock_control i_adc_sequence_and_clock_control (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .chip_select_n(cs_n), .read_strobe_n(rd_n), .load_strobe_n(ld_n),
    .data_in, .data_out, .data_oe, .ext_clock_or_include_ch1(mode ? ext_clock : incs[0]),
    .clock_source_or_include_ch2(incs[1]), .include_ch3(incs[2]), .include_ch4(incs[3]),
    .pin_vs_register_sel(mode), .standby_n, .sample_start, .conv_result(result), .busy,
    .conversion_done_pulse_n(done_n), .conv_channel(chan), .standby_active());
  host_bus_model i_host_bus_model (.hclk, .hresetn, .load_req, .read_req, .clk_on,
    .value, .chip_select_n(cs_n), .read_strobe_n(rd_n), .load_strobe_n(ld_n), .data_in,
    .ext_clock);
  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task edge_ready;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    edge_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready;
    rd = hrdata;
  endtask
  // Pins flip after the start so a late change would show in the count
  task run(input int n, input int lo, input int hi, input logic stop, input logic [1:0] ch);
    int i;
    int d;
    d = 0;
    i = 0;
    @(posedge hclk);
    sample_start <= 1'b1;
    do begin
      @(posedge hclk);
      i++;
      if (i == 2) incs <= ~incs;
      if (stop && i == 10) standby_n <= 1'b0;
      if (done_n === 1'b0) d++;
      if (i == 5) check(chan, ch);
    end while ((i < 3 || busy === 1'b1) && i < 600);
    sample_start <= 1'b0;
    standby_n <= 1'b1;
    check(d, n);
    check(i >= lo && i <= hi, 1);
    if (i >= 600) print_verdict;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    run(3, 94, 104, 1'b0, 2'd0);
    check(data_out, result);
    load_req <= 1'b1;
    @(posedge hclk);
    load_req <= 1'b0;
    repeat (5) @(posedge hclk);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(rd[15:12], 4'h8);
    mode <= 1'b1;
    incs <= 4'h5;
    bus(1'b1, CTRL_OFFSET, 32'h3);
    run(1, 62, 72, 1'b0, 2'd3);
    incs <= 4'h2;
    clk_on <= 1'b1;
    run(1, 30, 40, 1'b0, 2'd3);
    run(0, 10, 14, 1'b1, 2'd3);
    read_req <= 1'b1;
    repeat (2) @(posedge hclk);
    check(data_oe, 1'b1);
    read_req <= 1'b0;
    bus(1'b0, COUNT_OFFSET, 32'h0);
    check(rd, 32'h5);
    print_verdict;
  end
endmodule // adc_sequence_and_clock_control_test
